//--- logic/eag_pkg.sv
// What this block does
// RULE1: Zero page: one operand byte is the low address, high byte forced zero.
// RULE2: Indexed zero page: operand plus offset register, carry dropped, stays in page zero.
// RULE3: Indexed absolute: 16-bit operand base plus first or second offset register.
// RULE4: Implied: no operand address bytes fetched; location follows from opcode.
// RULE5: Relative: signed operand byte added to next instruction address, -128..+127.
// RULE6: Indexed indirect: operand plus first offset, pointer low then next byte.
// RULE7: Indexed indirect pointer bytes both stay inside page zero.
// RULE8: Indirect indexed: pointer low plus second offset, carry into high byte.
// RULE9: Absolute indirect: operand word points to target word loaded into counter.
// RULE10: Absolute: first operand byte low address, second operand byte high address.
// RULE11: Immediate: byte after opcode is the operand, no further addressing.
// RULE12: All addresses are 16 bits and wrap modulo 65536.
package eag_pkg;
  typedef enum logic [3:0] {
    EAG_M_IMPLIED = 4'h0,
    EAG_M_IMMED = 4'h1,
    EAG_M_ZPAGE = 4'h2,
    EAG_M_ZPAGE_IDX = 4'h3,
    EAG_M_ABS = 4'h4,
    EAG_M_ABS_IDX = 4'h5,
    EAG_M_REL = 4'h6,
    EAG_M_IDX_IND = 4'h7,
    EAG_M_IND_IDX = 4'h8,
    EAG_M_ABS_IND = 4'h9
  } eag_mode_e;

  typedef enum logic [4:0] {
    EAG_S_IDLE = 5'h01,
    EAG_S_PTR_LO = 5'h02,
    EAG_S_PTR_HI = 5'h04,
    EAG_S_WAIT = 5'h08,
    EAG_S_DONE = 5'h10
  } eag_state_e;

  typedef struct packed {
    eag_mode_e mode;
    logic use_second;
    logic [7:0] op_lo;
    logic [7:0] op_hi;
    logic [15:0] next_pc;
  } eag_req_s;

  localparam logic [7:0] EAG_PAGE_ZERO = 8'h00;
  localparam logic [15:0] EAG_ONE = 16'h0001;
endpackage

//--- logic/eag_adder.sv
// 16-bit adder, carry out of the top simply lost so results wrap.
module eag_adder (
  input wire logic [15:0] i_a,
  input wire logic [15:0] i_b,
  output logic [15:0] o_sum
);
  // RULE12 wrap 16 bits
  assign o_sum = 16'(i_a + i_b);
endmodule // eag_adder

//--- logic/eag_top.sv
// Sequences address generation for one instruction. Pointer modes read two bytes from memory.
module eag_top (
  input wire logic I_CLK,
  input wire logic I_NRST,
  input wire logic I_CE,
  input wire logic I_START,
  input wire eag_pkg::eag_req_s I_REQ,
  input wire logic [7:0] I_IDX_FIRST,
  input wire logic [7:0] I_IDX_SECOND,
  input wire logic I_RD_VALID,
  input wire logic [7:0] I_RD_DATA,
  output logic O_BUSY,
  output logic O_RD_REQ,
  output logic [15:0] O_RD_ADDR,
  output logic O_DONE,
  output logic [15:0] O_ADDR,
  output logic O_ADDR_VALID,
  output logic O_LOAD_PC
);
  typedef struct packed {
    eag_pkg::eag_state_e st;
    eag_pkg::eag_req_s req;
    logic [7:0] idx1;
    logic [7:0] idx2;
    logic [15:0] ptr;
    logic [7:0] lo;
    logic hi_phase;
    logic rd_req;
    logic [15:0] rd_addr;
    logic done;
    logic [15:0] addr;
    logic addr_valid;
    logic load_pc;
    logic busy;
  } eag_state_s;

  eag_state_s s_q;
  eag_state_s s_d;
  logic [15:0] add_a;
  logic [15:0] add_b;
  logic [15:0] add_sum;
  logic [15:0] ptr_next;

  eag_adder u_add (
    .i_a(add_a),
    .i_b(add_b),
    .o_sum(add_sum)
  );

  always_comb begin
    add_a = {s_q.req.op_hi, s_q.req.op_lo};
    add_b = 16'h0000;
    case (s_q.req.mode)
      eag_pkg::EAG_M_ABS_IDX: begin
        // RULE3 base plus index
        add_b = {8'h00, s_q.req.use_second ? s_q.idx2 : s_q.idx1};
      end
      eag_pkg::EAG_M_REL: begin
        // RULE5 signed offset
        add_a = s_q.req.next_pc;
        add_b = {{8{s_q.req.op_lo[7]}}, s_q.req.op_lo};
      end
      eag_pkg::EAG_M_IND_IDX: begin
        // RULE8 carry into high byte
        add_a = {I_RD_DATA, s_q.lo};
        add_b = {8'h00, s_q.idx2};
      end
      default: begin
        add_b = 16'h0000;
      end
    endcase
  end

  // RULE7 pointer stays in page zero
  // Only page-zero pointers wrap in the page; an absolute pointer steps over it
  always_comb begin
    if (s_q.req.mode == eag_pkg::EAG_M_ABS_IND) begin
      ptr_next = 16'(s_q.ptr + eag_pkg::EAG_ONE);
    end else begin
      ptr_next = {eag_pkg::EAG_PAGE_ZERO, 8'(s_q.ptr[7:0] + 8'h01)};
    end
  end

  always_comb begin
    s_d = s_q;
    s_d.done = 1'b0;
    s_d.addr_valid = 1'b0;
    s_d.load_pc = 1'b0;
    case (s_q.st)
      eag_pkg::EAG_S_IDLE: begin
        if (I_START) begin
          s_d.req = I_REQ;
          s_d.idx1 = I_IDX_FIRST;
          s_d.idx2 = I_IDX_SECOND;
          s_d.st = eag_pkg::EAG_S_WAIT;
          s_d.hi_phase = 1'b0;
          case (I_REQ.mode)
            eag_pkg::EAG_M_IDX_IND: begin
              // RULE6 operand plus first offset
              s_d.ptr = {eag_pkg::EAG_PAGE_ZERO, 8'(I_REQ.op_lo + I_IDX_FIRST)};
              s_d.st = eag_pkg::EAG_S_PTR_LO;
            end
            eag_pkg::EAG_M_IND_IDX: begin
              s_d.ptr = {eag_pkg::EAG_PAGE_ZERO, I_REQ.op_lo};
              s_d.st = eag_pkg::EAG_S_PTR_LO;
            end
            eag_pkg::EAG_M_ABS_IND: begin
              // RULE9 full pointer
              s_d.ptr = {I_REQ.op_hi, I_REQ.op_lo};
              s_d.st = eag_pkg::EAG_S_PTR_LO;
            end
            default: begin
              s_d.st = eag_pkg::EAG_S_DONE;
            end
          endcase
        end
      end
      eag_pkg::EAG_S_PTR_LO: begin
        s_d.rd_req = 1'b1;
        s_d.rd_addr = s_q.hi_phase ? ptr_next : s_q.ptr;
        s_d.st = eag_pkg::EAG_S_WAIT;
      end
      eag_pkg::EAG_S_WAIT: begin
        if (I_RD_VALID) begin
          s_d.rd_req = 1'b0;
          if (!s_q.hi_phase) begin
            s_d.lo = I_RD_DATA;
            s_d.hi_phase = 1'b1;
            s_d.st = eag_pkg::EAG_S_PTR_LO;
          end else begin
            s_d.st = eag_pkg::EAG_S_PTR_HI;
          end
        end
      end
      eag_pkg::EAG_S_PTR_HI: begin
        s_d.st = eag_pkg::EAG_S_IDLE;
        s_d.done = 1'b1;
        s_d.addr_valid = 1'b1;
        s_d.addr = {I_RD_DATA, s_q.lo};
        if (s_q.req.mode == eag_pkg::EAG_M_IND_IDX) begin
          s_d.addr = add_sum;
        end
        s_d.load_pc = (s_q.req.mode == eag_pkg::EAG_M_ABS_IND);
      end
      eag_pkg::EAG_S_DONE: begin
        s_d.st = eag_pkg::EAG_S_IDLE;
        s_d.done = 1'b1;
        s_d.addr_valid = 1'b1;
        case (s_q.req.mode)
          eag_pkg::EAG_M_ZPAGE: begin
            // RULE1 high byte zero
            s_d.addr = {eag_pkg::EAG_PAGE_ZERO, s_q.req.op_lo};
          end
          eag_pkg::EAG_M_ZPAGE_IDX: begin
            // RULE2 carry discarded
            s_d.addr = {eag_pkg::EAG_PAGE_ZERO,
                        8'(s_q.req.op_lo + (s_q.req.use_second ? s_q.idx2 : s_q.idx1))};
          end
          eag_pkg::EAG_M_ABS: begin
            // RULE10 low then high
            s_d.addr = {s_q.req.op_hi, s_q.req.op_lo};
          end
          eag_pkg::EAG_M_ABS_IDX: begin
            s_d.addr = add_sum;
          end
          eag_pkg::EAG_M_REL: begin
            s_d.addr = add_sum;
            s_d.load_pc = 1'b1;
          end
          default: begin
            // RULE4 implied no address
            // RULE11 immediate no address
            s_d.addr_valid = 1'b0;
            s_d.addr = 16'h0000;
          end
        endcase
      end
      default: begin
        s_d.st = eag_pkg::EAG_S_IDLE;
      end
    endcase
    // Busy is registered so the output comes straight from a flop
    s_d.busy = (s_d.st != eag_pkg::EAG_S_IDLE);
  end

  always_ff @(posedge I_CLK) begin
    if (!I_NRST) begin
      s_q <= '0;
      s_q.st <= eag_pkg::EAG_S_IDLE;
    end else if (I_CE) begin
      s_q <= s_d;
    end
  end

  assign O_BUSY = s_q.busy;
  assign O_RD_REQ = s_q.rd_req;
  assign O_RD_ADDR = s_q.rd_addr;
  assign O_DONE = s_q.done;
  assign O_ADDR = s_q.addr;
  assign O_ADDR_VALID = s_q.addr_valid;
  assign O_LOAD_PC = s_q.load_pc;

  zp_high_a: assert property (@(posedge I_CLK) disable iff (!I_NRST) // RULE1
    (I_CE && s_q.st == eag_pkg::EAG_S_DONE && s_q.req.mode == eag_pkg::EAG_M_ZPAGE) |=>
    (O_ADDR == {8'h00, $past(s_q.req.op_lo)})) else $error("zero page address wrong");
  zpx_page_a: assert property (@(posedge I_CLK) disable iff (!I_NRST) // RULE2
    (I_CE && s_q.st == eag_pkg::EAG_S_DONE && s_q.req.mode == eag_pkg::EAG_M_ZPAGE_IDX) |=>
    (O_ADDR[15:8] == 8'h00)) else $error("indexed zero page left page zero");
  absx_sum_a: assert property (@(posedge I_CLK) disable iff (!I_NRST) // RULE3
    (I_CE && s_q.st == eag_pkg::EAG_S_DONE && s_q.req.mode == eag_pkg::EAG_M_ABS_IDX) |=>
    (O_ADDR == 16'({$past(s_q.req.op_hi), $past(s_q.req.op_lo)} +
     {8'h00, $past(s_q.req.use_second) ? $past(s_q.idx2) : $past(s_q.idx1)})))
    else $error("indexed absolute sum wrong");
  implied_nord_a: assert property (@(posedge I_CLK) disable iff (!I_NRST) // RULE4
    (s_q.req.mode == eag_pkg::EAG_M_IMPLIED && O_BUSY) |-> !O_RD_REQ)
    else $error("implied mode read memory");
  rel_pc_a: assert property (@(posedge I_CLK) disable iff (!I_NRST) // RULE5
    (I_CE && s_q.st == eag_pkg::EAG_S_DONE && s_q.req.mode == eag_pkg::EAG_M_REL) |=>
    (O_LOAD_PC && O_ADDR == 16'($past(s_q.req.next_pc) + {{8{$past(s_q.req.op_lo[7])}}, $past(s_q.req.op_lo)})))
    else $error("branch target wrong");
  idxind_zp_a: assert property (@(posedge I_CLK) disable iff (!I_NRST) // RULE7
    (O_RD_REQ && s_q.req.mode == eag_pkg::EAG_M_IDX_IND) |-> (O_RD_ADDR[15:8] == 8'h00))
    else $error("pointer left page zero");
  absind_pc_a: assert property (@(posedge I_CLK) disable iff (!I_NRST) // RULE9
    (I_CE && s_q.st == eag_pkg::EAG_S_PTR_HI && s_q.req.mode == eag_pkg::EAG_M_ABS_IND) |=> O_LOAD_PC)
    else $error("indirect jump did not load counter");
  abs_order_a: assert property (@(posedge I_CLK) disable iff (!I_NRST) // RULE10
    (I_CE && s_q.st == eag_pkg::EAG_S_DONE && s_q.req.mode == eag_pkg::EAG_M_ABS) |=>
    (O_ADDR_VALID && O_ADDR == {$past(s_q.req.op_hi), $past(s_q.req.op_lo)}))
    else $error("absolute byte order wrong");
  imm_noaddr_a: assert property (@(posedge I_CLK) disable iff (!I_NRST) // RULE11
    (s_q.req.mode == eag_pkg::EAG_M_IMMED && O_BUSY) |-> !O_RD_REQ)
    else $error("immediate mode read memory");
  ptr_ind_c: cover property (@(posedge I_CLK) disable iff (!I_NRST)
    O_DONE && s_q.req.mode == eag_pkg::EAG_M_IND_IDX);
  rel_c: cover property (@(posedge I_CLK) disable iff (!I_NRST)
    O_LOAD_PC && s_q.req.mode == eag_pkg::EAG_M_REL);
  jmp_c: cover property (@(posedge I_CLK) disable iff (!I_NRST)
    O_LOAD_PC && s_q.req.mode == eag_pkg::EAG_M_ABS_IND);
endmodule // eag_top

//--- verification/eag_mem_model.sv
// Memory partner: answers each read after i_dly cycles with a byte derived from the address.
module eag_mem_model (
  input wire logic i_clk,
  input wire logic i_rd_req,
  input wire logic [15:0] i_rd_addr,
  input wire logic [3:0] i_dly,
  output logic o_valid,
  output logic [7:0] o_data
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] cnt;
  logic hold;
  initial begin
    o_valid = 1'b0;
    o_data = 8'hA5;
    cnt = 4'h0;
    hold = 1'b0;
  end
  // Data stays one edge past the valid edge, then scrambles so stale bytes cannot pass
  always @(negedge i_clk) begin
    if (i_rd_req && !o_valid && cnt == i_dly) begin
      o_valid <= 1'b1;
      o_data <= i_rd_addr[7:0] ^ i_rd_addr[15:8] ^ 8'h5A;
      hold <= 1'b1;
      cnt <= 4'h0;
    end else begin
      o_valid <= 1'b0;
      hold <= 1'b0;
      if (!hold) begin
        o_data <= ~o_data;
      end
      cnt <= (i_rd_req && !o_valid) ? cnt + 4'h1 : 4'h0;
    end
  end
endmodule // eag_mem_model

//--- verification/effective_address_generator_test.sv
module effective_address_generator_test;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct {
    eag_pkg::eag_req_s req;
    logic [7:0] x;
    logic [7:0] y;
    logic [15:0] a;
    logic [3:0] f;
  } eag_row_s;
  logic I_CLK, I_NRST, I_CE, I_START, I_RD_VALID, O_BUSY, O_RD_REQ, O_DONE, O_ADDR_VALID, O_LOAD_PC, saw_rd;
  logic [7:0] I_IDX_FIRST, I_IDX_SECOND, I_RD_DATA;
  logic [15:0] O_RD_ADDR, O_ADDR;
  logic [3:0] dly;
  eag_pkg::eag_req_s I_REQ;
  int n_errors, checked, cycles;
  eag_row_s rows[14];
  eag_top eag_top_inst (.I_CLK(I_CLK), .I_NRST(I_NRST), .I_CE(I_CE), .I_START(I_START), .I_REQ(I_REQ),
    .I_IDX_FIRST(I_IDX_FIRST), .I_IDX_SECOND(I_IDX_SECOND), .I_RD_VALID(I_RD_VALID), .I_RD_DATA(I_RD_DATA),
    .O_BUSY(O_BUSY), .O_RD_REQ(O_RD_REQ), .O_RD_ADDR(O_RD_ADDR), .O_DONE(O_DONE), .O_ADDR(O_ADDR),
    .O_ADDR_VALID(O_ADDR_VALID), .O_LOAD_PC(O_LOAD_PC));
  eag_mem_model eag_mem_model_inst (.i_clk(I_CLK), .i_rd_req(O_RD_REQ), .i_rd_addr(O_RD_ADDR), .i_dly(dly),
    .o_valid(I_RD_VALID), .o_data(I_RD_DATA));
  function automatic logic [7:0] m(input logic [15:0] a);
    return a[7:0] ^ a[15:8] ^ 8'h5A;
  endfunction
  function automatic eag_row_s r(input eag_pkg::eag_mode_e md, input logic s, input logic [7:0] lo, input logic [7:0] hi,
    input logic [15:0] pc, input logic [7:0] x, input logic [7:0] y, input logic [15:0] a, input logic [3:0] f);
    return '{'{md, s, lo, hi, pc}, x, y, a, f};
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_of_test();
    if (n_errors == 0 && checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // Flags are {check address, reads seen, address valid, load counter}
  task automatic run(input eag_row_s w);
    int k;
    I_REQ = w.req;
    I_IDX_FIRST = w.x;
    I_IDX_SECOND = w.y;
    I_START = 1'b1;
    saw_rd = 1'b0;
    @(negedge I_CLK);
    I_START = 1'b0;
    for (k = 0; k < 40 && O_DONE !== 1'b1; k++) begin
      saw_rd |= (O_RD_REQ === 1'b1);
      @(negedge I_CLK);
    end
    check(O_DONE, 1);
    check({saw_rd, O_ADDR_VALID, O_LOAD_PC}, w.f[2:0]);
    if (w.f[3]) begin
      check(O_ADDR, w.a);
    end
    repeat (2) @(negedge I_CLK);
  endtask
  initial begin
    I_CLK = 1'b0;
    forever #20 I_CLK = ~I_CLK;
  end
  always @(posedge I_CLK) begin
    cycles++;
    if (cycles == 2000) begin
      n_errors++;
      end_of_test();
    end
  end
  initial begin
    I_NRST = 1'b0;
    I_CE = 1'b1;
    I_START = 1'b0;
    I_REQ = '0;
    I_IDX_FIRST = 8'h00;
    I_IDX_SECOND = 8'h00;
    dly = 4'h0;
    rows[0] = r(eag_pkg::EAG_M_ZPAGE, 1'b0, 8'hF3, 8'h77, 16'h0000, 8'h11, 8'h22, 16'h00F3, 4'hA);
    rows[1] = r(eag_pkg::EAG_M_ZPAGE_IDX, 1'b0, 8'hF0, 8'h00, 16'h0000, 8'h20, 8'h05, 16'h0010, 4'hA);
    rows[2] = r(eag_pkg::EAG_M_ZPAGE_IDX, 1'b1, 8'h10, 8'h00, 16'h0000, 8'h07, 8'h34, 16'h0044, 4'hA);
    rows[3] = r(eag_pkg::EAG_M_ABS, 1'b0, 8'h34, 8'h12, 16'h0000, 8'h01, 8'h02, 16'h1234, 4'hA);
    rows[4] = r(eag_pkg::EAG_M_ABS_IDX, 1'b0, 8'hF0, 8'hFF, 16'h0000, 8'h20, 8'h03, 16'h0010, 4'hA);
    rows[5] = r(eag_pkg::EAG_M_ABS_IDX, 1'b1, 8'hFF, 8'h12, 16'h0000, 8'h09, 8'h01, 16'h1300, 4'hA);
    rows[6] = r(eag_pkg::EAG_M_REL, 1'b0, 8'h80, 8'h00, 16'h1000, 8'h00, 8'h00, 16'h0F80, 4'hB);
    rows[7] = r(eag_pkg::EAG_M_REL, 1'b0, 8'h7F, 8'h00, 16'hFFF0, 8'h00, 8'h00, 16'h006F, 4'hB);
    rows[8] = r(eag_pkg::EAG_M_IMPLIED, 1'b0, 8'h12, 8'h34, 16'h0000, 8'h00, 8'h00, 16'h0000, 4'h0);
    rows[9] = r(eag_pkg::EAG_M_IMMED, 1'b0, 8'h55, 8'h66, 16'h0000, 8'h00, 8'h00, 16'h0000, 4'h0);
    rows[10] = r(eag_pkg::EAG_M_IDX_IND, 1'b0, 8'hF0, 8'h00, 16'h0000, 8'h0F, 8'h00, {m(16'h0000), m(16'h00FF)}, 4'hE);
    rows[11] = r(eag_pkg::EAG_M_IND_IDX, 1'b0, 8'hFE, 8'h00, 16'h0000, 8'h00, 8'hF0,
      {m(16'h00FF), m(16'h00FE)} + 16'h00F0, 4'hE);
    rows[12] = r(eag_pkg::EAG_M_ABS_IND, 1'b0, 8'hFF, 8'h12, 16'h0000, 8'h00, 8'h00, {m(16'h1300), m(16'h12FF)}, 4'hF);
    // An absolute pointer at the end of page zero must step into the next page
    rows[13] = r(eag_pkg::EAG_M_ABS_IND, 1'b0, 8'hFF, 8'h00, 16'h0000, 8'h00, 8'h00, {m(16'h0100), m(16'h00FF)}, 4'hF);
    repeat (16) @(negedge I_CLK);
    check({O_BUSY, O_RD_REQ, O_DONE, O_ADDR_VALID, O_LOAD_PC, O_ADDR}, 0);
    I_NRST = 1'b1;
    @(negedge I_CLK);
    foreach (rows[i]) begin
      run(rows[i]);
    end
    // A slow memory must not change the result
    dly = 4'h3;
    run(rows[11]);
    // Reset in the middle of a pointer fetch, then a clean operation
    I_REQ = rows[12].req;
    I_START = 1'b1;
    @(negedge I_CLK);
    I_START = 1'b0;
    repeat (3) @(negedge I_CLK);
    I_NRST = 1'b0;
    repeat (2) @(negedge I_CLK);
    check({O_BUSY, O_RD_REQ, O_DONE, O_ADDR_VALID, O_LOAD_PC, O_ADDR}, 0);
    I_NRST = 1'b1;
    @(negedge I_CLK);
    run(rows[0]);
    // A low clock enable freezes the block in the middle of an operation
    I_REQ = rows[3].req;
    I_START = 1'b1;
    @(negedge I_CLK);
    I_START = 1'b0;
    I_CE = 1'b0;
    repeat (3) @(negedge I_CLK);
    check({O_BUSY, O_DONE}, 2'b10);
    I_CE = 1'b1;
    @(negedge I_CLK);
    check({O_DONE, O_ADDR_VALID, O_ADDR}, {2'b11, 16'h1234});
    repeat (2) @(negedge I_CLK);
    end_of_test();
  end
endmodule // effective_address_generator_test
